// ==== ddfd_map.svh ====
// field positions, codes and timing of the destination doubleword decoder
// Function
// - region word is bits 31 down to 16
// - region subfields split by addressing mode
// - producer sets stride 01 when sixteen-byte aligned
// - bits 14:12 give second source type
// - datapath uses coded type, no coercion
// - register operand uses register type table
// - immediate operand uses immediate type table
// - register table equals destination type table
// - immediate table has no byte types
// - immediate table has three packed vectors
// - one immediate only, last source only
// - halfbyte vector only in packed-word mode
// - halfbyte vector needs byte/word first source
// - register codes 000 uint32, 001 int32, 010 uint16
// - 011-101 narrow integers, 111 float, 110 reserved
// - immediate 100 unsigned halfbyte, 101 float, 110 halfbyte
`ifndef DDFD_MAP_SVH
`define DDFD_MAP_SVH
`define DDFD_REGION_MSB   31
`define DDFD_REGION_LSB   16
`define DDFD_RSVD_BIT     15
`define DDFD_TYPE_MSB     14
`define DDFD_TYPE_LSB     12
`define DDFD_HSTRIDE_MSB  1
`define DDFD_HSTRIDE_LSB  0
`define DDFD_HSTRIDE_A16  2'h1
`define DDFD_CODE_RSVD    3'h6
`define DDFD_CODE_I_RSVD  3'h7
`define DDFD_LATENCY      1
`endif

// ==== ddfd_pkg.sv ====
// types of the destination doubleword decoder
package ddfd_pkg;
	typedef enum logic [3:0] {
		DDFD_K_UINT32, DDFD_K_D, DDFD_K_UINT16, DDFD_K_W, DDFD_K_UINT8, DDFD_K_B, DDFD_K_F,
		DDFD_K_UNSIGNED_HALFBYTE_PACK, DDFD_K_EXP_FLOAT_PACK, DDFD_K_V, DDFD_K_BAD
	} ddfd_kind_t;
	typedef enum logic {DDFD_BYTE_ALIGNED_MODE, DDFD_SIXTEEN_BYTE_ALIGNED_MODE} ddfd_mode_t;
	typedef enum logic {DDFD_FILE_REG, DDFD_FILE_IMM} ddfd_file_t;
endpackage

// ==== ddfd_if.sv ====
// issue-to-decoder link of the destination doubleword decoder
`timescale 1ns/100ps
interface ddfd_if;
	import ddfd_pkg::*;
	logic               valid;
	logic [31:0]        destination_doubleword;
	ddfd_mode_t         operand_addressing_mode;
	ddfd_file_t         src0_file_select;
	ddfd_file_t         operand_file_select;
	logic               two_source;
	logic               packed_word_mode;
	ddfd_kind_t         src0_kind;
	logic               out_valid;
	logic [15:0]        dest_region;
	logic [1:0]         dest_horizontal_stride;
	ddfd_kind_t         second_source_type;
	logic               illegal_encoding;
	modport issue  (output valid, destination_doubleword, operand_addressing_mode,
		src0_file_select, operand_file_select, two_source, packed_word_mode, src0_kind,
		input out_valid, dest_region, dest_horizontal_stride, second_source_type,
		illegal_encoding);
	modport decode (input valid, destination_doubleword, operand_addressing_mode,
		src0_file_select, operand_file_select, two_source, packed_word_mode, src0_kind,
		output out_valid, dest_region, dest_horizontal_stride, second_source_type,
		illegal_encoding);
endinterface

// ==== ddfd_issue.sv ====
// issue end: packs an instruction's destination doubleword onto the link
`timescale 1ns/100ps
`include "ddfd_map.svh"
module ddfd_issue (
	input  wire logic                 clk,
	input  wire logic                 rst,
	input  wire logic                 req_valid,
	input  wire logic [15:0]          req_region,
	input  wire logic [2:0]           req_src1_code,
	input  wire ddfd_pkg::ddfd_mode_t req_mode,
	input  wire ddfd_pkg::ddfd_file_t req_src0_file,
	input  wire ddfd_pkg::ddfd_file_t req_src1_file,
	input  wire logic                 req_two_source,
	input  wire logic                 req_packed_word,
	input  wire ddfd_pkg::ddfd_kind_t req_src0_kind,
	output logic                      rsp_valid,
	output ddfd_pkg::ddfd_kind_t      rsp_type,
	output logic [15:0]               rsp_region,
	output logic                      rsp_illegal,
	ddfd_if.issue                     link
);
	import ddfd_pkg::*;
	logic        v_q;
	logic [31:0] dw_q;
	logic [15:0] region_fix;
	ddfd_mode_t  mode_q;
	ddfd_file_t  src0_file_q;
	ddfd_file_t  src1_file_q;
	logic        two_q;
	logic        pw_q;
	ddfd_kind_t  src0_kind_q;
	assign region_fix = (req_mode == DDFD_SIXTEEN_BYTE_ALIGNED_MODE) ?
		{req_region[15:2], `DDFD_HSTRIDE_A16} : req_region;
	// side fields ride with the doubleword so back-to-back issue stays aligned
	always_ff @(posedge clk) begin
		if (rst) begin
			v_q         <= 1'b0;
			dw_q        <= 32'h0;
			mode_q      <= DDFD_BYTE_ALIGNED_MODE;
			src0_file_q <= DDFD_FILE_REG;
			src1_file_q <= DDFD_FILE_REG;
			two_q       <= 1'b0;
			pw_q        <= 1'b0;
			src0_kind_q <= DDFD_K_UINT32;
		end else begin
			v_q         <= req_valid;
			dw_q        <= {region_fix, 1'b0, req_src1_code, 12'h000};
			mode_q      <= req_mode;
			src0_file_q <= req_src0_file;
			src1_file_q <= req_src1_file;
			two_q       <= req_two_source;
			pw_q        <= req_packed_word;
			src0_kind_q <= req_src0_kind;
		end
	end
	assign link.valid                   = v_q;
	assign link.destination_doubleword  = dw_q;
	assign link.operand_addressing_mode = mode_q;
	assign link.src0_file_select        = src0_file_q;
	assign link.operand_file_select     = src1_file_q;
	assign link.two_source              = two_q;
	assign link.packed_word_mode        = pw_q;
	assign link.src0_kind               = src0_kind_q;
	assign rsp_valid   = link.out_valid;
	assign rsp_type    = link.second_source_type;
	assign rsp_region  = link.dest_region;
	assign rsp_illegal = link.illegal_encoding;
endmodule // ddfd_issue

// ==== ddfd_decode.sv ====
// decoder end: splits the destination doubleword and checks its encodings
`timescale 1ns/100ps
`include "ddfd_map.svh"
module ddfd_decode (
	input  wire logic           clk,
	input  wire logic           rst,
	output logic                ex_valid,
	output ddfd_pkg::ddfd_kind_t ex_src1_kind,
	output logic [15:0]         ex_dest_region,
	output logic [1:0]          ex_dest_horizontal_stride,
	output logic                ex_illegal,
	ddfd_if.decode              link
);
	import ddfd_pkg::*;
	ddfd_kind_t  kind_reg;
	ddfd_kind_t  kind_imm;
	ddfd_kind_t  kind_sel;
	logic [15:0] region;
	logic [2:0]  code;
	logic        rsvd_bad;
	logic        code_bad;
	logic        imm_bad;
	logic        vec_bad;
	logic        src0_small;
	logic        v_q;
	logic        ill_q;
	logic [15:0] region_q;
	logic [1:0]  stride_q;
	ddfd_kind_t  kind_q;
	assign region = link.destination_doubleword[`DDFD_REGION_MSB:`DDFD_REGION_LSB];
	assign code = link.destination_doubleword[`DDFD_TYPE_MSB:`DDFD_TYPE_LSB];
	always_comb begin
		unique case (code)
			3'h0: kind_reg = DDFD_K_UINT32;
			3'h1: kind_reg = DDFD_K_D;
			3'h2: kind_reg = DDFD_K_UINT16;
			3'h3: kind_reg = DDFD_K_W;
			3'h4: kind_reg = DDFD_K_UINT8;
			3'h5: kind_reg = DDFD_K_B;
			3'h6: kind_reg = DDFD_K_BAD;
			3'h7: kind_reg = DDFD_K_F;
		endcase
	end
	always_comb begin
		unique case (code)
			3'h0: kind_imm = DDFD_K_UINT32;
			3'h1: kind_imm = DDFD_K_D;
			3'h2: kind_imm = DDFD_K_UINT16;
			3'h3: kind_imm = DDFD_K_W;
			3'h4: kind_imm = DDFD_K_UNSIGNED_HALFBYTE_PACK;
			3'h5: kind_imm = DDFD_K_EXP_FLOAT_PACK;
			3'h6: kind_imm = DDFD_K_V;
			3'h7: kind_imm = DDFD_K_BAD;
		endcase
	end
	assign kind_sel = (link.operand_file_select == DDFD_FILE_IMM) ? kind_imm : kind_reg;
	assign rsvd_bad = link.destination_doubleword[`DDFD_RSVD_BIT];
	assign code_bad = (kind_sel == DDFD_K_BAD);
	assign imm_bad = (link.src0_file_select == DDFD_FILE_IMM) &&
		(link.two_source || link.operand_file_select == DDFD_FILE_IMM);
	assign src0_small = (link.src0_kind == DDFD_K_UINT8) || (link.src0_kind == DDFD_K_B) ||
		(link.src0_kind == DDFD_K_UINT16) || (link.src0_kind == DDFD_K_W);
	assign vec_bad = (kind_sel == DDFD_K_V) &&
		(!link.packed_word_mode || (link.two_source && !src0_small));
	always_ff @(posedge clk) begin
		if (rst) begin
			v_q      <= 1'b0;
			ill_q    <= 1'b0;
			region_q <= 16'h0000;
			stride_q <= 2'h0;
			kind_q   <= DDFD_K_UINT32;
		end else begin
			v_q      <= link.valid;
			ill_q    <= link.valid && (rsvd_bad || code_bad || imm_bad || vec_bad);
			region_q <= region;
			stride_q <= (link.operand_addressing_mode == DDFD_SIXTEEN_BYTE_ALIGNED_MODE) ?
				`DDFD_HSTRIDE_A16 : region[`DDFD_HSTRIDE_MSB:`DDFD_HSTRIDE_LSB];
			kind_q   <= kind_sel;
		end
	end
	assign ex_valid                  = v_q;
	assign ex_src1_kind              = kind_q;
	assign ex_dest_region            = region_q;
	assign ex_dest_horizontal_stride = stride_q;
	assign ex_illegal                = ill_q;
	assign link.out_valid              = v_q;
	assign link.dest_region            = region_q;
	assign link.dest_horizontal_stride = stride_q;
	assign link.second_source_type     = kind_q;
	assign link.illegal_encoding       = ill_q;
endmodule // ddfd_decode

// ==== ddfd_monitor.sv ====
// concurrent checks on the issue-to-decoder link
`timescale 1ns/100ps
module ddfd_monitor (
	input wire logic                 clk,
	input wire logic                 rst,
	input wire logic                 valid,
	input wire logic [31:0]          destination_doubleword,
	input wire ddfd_pkg::ddfd_mode_t operand_addressing_mode,
	input wire ddfd_pkg::ddfd_file_t operand_file_select,
	input wire logic                 packed_word_mode,
	input wire logic                 out_valid,
	input wire logic [15:0]          dest_region,
	input wire logic [1:0]           dest_horizontal_stride,
	input wire ddfd_pkg::ddfd_kind_t second_source_type,
	input wire logic                 illegal_encoding
);
	import ddfd_pkg::*;
	localparam ddfd_kind_t RK [8] = '{DDFD_K_UINT32, DDFD_K_D, DDFD_K_UINT16, DDFD_K_W,
		DDFD_K_UINT8, DDFD_K_B, DDFD_K_BAD, DDFD_K_F};
	localparam ddfd_kind_t IK [8] = '{DDFD_K_UINT32, DDFD_K_D, DDFD_K_UINT16, DDFD_K_W,
		DDFD_K_UNSIGNED_HALFBYTE_PACK, DDFD_K_EXP_FLOAT_PACK, DDFD_K_V, DDFD_K_BAD};
	wire logic [2:0]  code = destination_doubleword[14:12];
	wire logic [15:0] rgn = destination_doubleword[31:16];
	wire logic        imm = operand_file_select == DDFD_FILE_IMM;
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	sequence s_answer;
		##1 out_valid;
	endsequence
	out_pulse_a: assert property (valid |-> s_answer)
		else $error("no answer to request");
	idle_quiet_a: assert property (!valid |=> !out_valid)
		else $error("answer without request");
	region_word_a: assert property (valid |=> dest_region == $past(rgn))
		else $error("region word mismatch");
	aligned_stride_a: assert property (valid &&
		operand_addressing_mode == DDFD_SIXTEEN_BYTE_ALIGNED_MODE
		|=> dest_horizontal_stride == 2'h1) else $error("aligned mode stride not 01");
	reg_table_a: assert property (valid && !imm && code != 3'h6
		|=> second_source_type == RK[$past(code)]) else $error("register type wrong");
	imm_table_a: assert property (valid && imm && code < 3'h6
		|=> second_source_type == IK[$past(code)]) else $error("immediate type wrong");
	reg_reserved_a: assert property (valid && !imm && code == 3'h6
		|=> illegal_encoding) else $error("reserved register code passed");
	imm_reserved_a: assert property (valid && imm && code == 3'h7
		|=> illegal_encoding) else $error("reserved immediate code passed");
	vec_mode_a: assert property (valid && imm && code == 3'h6 && !packed_word_mode
		|=> illegal_encoding) else $error("vector outside packed mode passed");
endmodule // ddfd_monitor

// ==== dest_dword_field_decoder_tb.sv ====
// self-checking bench: issue end driving decoder end
`timescale 1ns/100ps
`include "ddfd_map.svh"
module dest_dword_field_decoder_tb;
	import ddfd_pkg::*;
	logic       clk, rst, req_valid, two, pw, mode, f0, f1, rv, ri, xv, xi;
	logic [15:0] rgn, rr, xr;
	logic [2:0] code;
	logic [3:0] k0;
	logic [1:0] xs;
	ddfd_kind_t rt, xk;
	int         fail_count = 0;
	int         total_checks = 0;
	localparam ddfd_kind_t REG_K [8] = '{DDFD_K_UINT32, DDFD_K_D, DDFD_K_UINT16, DDFD_K_W,
		DDFD_K_UINT8, DDFD_K_B, DDFD_K_BAD, DDFD_K_F};
	localparam ddfd_kind_t IMM_K [8] = '{DDFD_K_UINT32, DDFD_K_D, DDFD_K_UINT16, DDFD_K_W,
		DDFD_K_UNSIGNED_HALFBYTE_PACK, DDFD_K_EXP_FLOAT_PACK, DDFD_K_V, DDFD_K_BAD};
	ddfd_if link_if ();
	ddfd_issue ddfd_issue_i (.clk(clk), .rst(rst), .req_valid(req_valid), .req_region(rgn),
		.req_src1_code(code), .req_mode(ddfd_mode_t'(mode)), .req_src0_file(ddfd_file_t'(f0)),
		.req_src1_file(ddfd_file_t'(f1)), .req_two_source(two), .req_packed_word(pw),
		.req_src0_kind(ddfd_kind_t'(k0)), .rsp_valid(rv), .rsp_type(rt), .rsp_region(rr),
		.rsp_illegal(ri), .link(link_if.issue));
	ddfd_decode ddfd_decode_i (.clk(clk), .rst(rst), .ex_valid(xv), .ex_src1_kind(xk),
		.ex_dest_region(xr), .ex_dest_horizontal_stride(xs), .ex_illegal(xi), .link(link_if.decode));
	ddfd_monitor ddfd_monitor_i (.clk(clk), .rst(rst), .valid(link_if.valid),
		.destination_doubleword(link_if.destination_doubleword),
		.operand_addressing_mode(link_if.operand_addressing_mode),
		.operand_file_select(link_if.operand_file_select), .packed_word_mode(link_if.packed_word_mode),
		.out_valid(link_if.out_valid), .dest_region(link_if.dest_region),
		.dest_horizontal_stride(link_if.dest_horizontal_stride),
		.second_source_type(link_if.second_source_type), .illegal_encoding(link_if.illegal_encoding));
	task automatic chk_kind(string n, ddfd_kind_t e, ddfd_kind_t g);
		total_checks++;
		if (g !== e) begin
			fail_count++;
			$display("unexpected %s exp %s got %s", n, e.name(), g.name());
		end
	endtask
	task automatic chk_bits(string n, logic [15:0] e, logic [15:0] g);
		total_checks++;
		if (g !== e) begin
			fail_count++;
			$display("unexpected %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic send(logic [15:0] r, logic [2:0] c, logic [4:0] sel, logic [3:0] k, logic bad,
		ddfd_kind_t ek);
		logic [15:0] er;
		er = sel[4] ? {r[15:2], 2'h1} : r;
		{rgn, code, mode, f0, f1, two, pw, k0, req_valid} = {r, c, sel, k, 1'h1};
		@(negedge clk);
		req_valid = 1'h0;
		@(negedge clk);
		chk_bits("flags", {12'h000, 2'h3, bad, bad}, {12'h000, xv, rv, xi, ri});
		chk_bits("region", er, xr);
		chk_bits("rsp_region", er, rr);
		chk_bits("stride", {14'h0, er[`DDFD_HSTRIDE_MSB:`DDFD_HSTRIDE_LSB]}, {14'h0, xs});
		if (!bad) begin
			chk_kind("kind", ek, xk);
			chk_kind("rsp_kind", ek, rt);
		end
	endtask
	task automatic test_done;
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	initial begin
		clk = 1'h0;
		forever #2.5 clk = ~clk;
	end
	initial begin
		repeat (300) @(posedge clk);
		fail_count++;
		test_done;
	end
	initial begin
		{rst, rgn, code, mode, f0, f1, two, pw, k0, req_valid} = {1'h1, 29'h0};
		repeat (8) @(negedge clk);
		rst = 1'h0;
		for (int i = 0; i < 8; i++) begin
			send({13'h0A2F, i[2:0]}, i[2:0], 5'h02, 4'h0, i == 6, REG_K[i]);
			send({13'h1C3B, i[2:0]}, i[2:0], 5'h07, DDFD_K_UINT8, i == 7, IMM_K[i]);
		end
		$display("test type tables done");
		send(16'hABCC, 3'h7, 5'h10, DDFD_K_UINT32, 1'h0, DDFD_K_F);
		send(16'h0F0F, 3'h6, 5'h06, DDFD_K_UINT8, 1'h1, DDFD_K_V);
		send(16'h0F0F, 3'h6, 5'h07, DDFD_K_D, 1'h1, DDFD_K_V);
		send(16'h0F0F, 3'h6, 5'h07, DDFD_K_W, 1'h0, DDFD_K_V);
		send(16'h5555, 3'h0, 5'h0A, DDFD_K_UINT32, 1'h1, DDFD_K_UINT32);
		send(16'h5555, 3'h0, 5'h0E, DDFD_K_UINT32, 1'h1, DDFD_K_UINT32);
		send(16'h3333, 3'h0, 5'h08, DDFD_K_UINT32, 1'h0, DDFD_K_UINT32);
		$display("test restrictions done");
		test_done;
	end
endmodule // dest_dword_field_decoder_tb
